// file: mgc_gpio_config.v
// Purpose: Configuration and pad control for pins 0 to 3 and pin 6 output value
// Assumes: Remote pin values and pin inputs arrive asynchronously
// Notes:   Second-port select steers all pad controls to the second pin set
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "mgc_gpio_regs.vh"

// What this block does
// - Second-port select routes each pin configuration to the second pin set.
// - Direction,enable decode: 00 functional, 10 tri-state, 01 gp out, 11 gp in.
// - Local output value drives pin only in gp output mode, remote off.
// - Remote control set makes pin an output driven by remote value.
// - Remote control clear ignores remote values; local settings govern.
// - Enable lives in bit 0, bit 4 for upper pin, resets zero.
// - Direction bits 1/5, remote bits 2/6, output value bits 3/7.
module mgc_gpio_config
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        second_port_select,
  input  wire [3:0]  remote_pin_value,
  input  wire [3:0]  func_out_value,
  input  wire [3:0]  pin_in,
  input  wire [3:0]  second_set_pin_in,
  output wire [3:0]  pin_out,
  output wire [3:0]  pin_oe,
  output wire [3:0]  second_set_pin_out,
  output wire [3:0]  second_set_pin_oe,
  output wire [3:0]  pin_in_value,
  output reg         pin_six_output_value
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [3:0] pin0_cfg_q;
reg  [3:0] pin0_cfg_d;
reg  [7:0] pin12_cfg_q;
reg  [7:0] pin12_cfg_d;
reg  [3:0] pin3_cfg_q;
reg  [3:0] pin3_cfg_d;
reg  [3:0] pin3_rsvd_q;
reg  [3:0] pin3_rsvd_d;
reg  [3:0] pin5_cfg_q;
reg  [3:0] pin5_cfg_d;
reg  [2:0] pin6_cfg_q;
reg  [2:0] pin6_cfg_d;
reg        pin6_out_d;
reg  [7:0] rdata_d;
wire       wr_pin0;
wire       wr_pin12;
wire       wr_pin3;
wire       wr_pin56;
wire [3:0] nib [0:3];

// Address decode
assign wr_pin0  = reg_wr & (reg_addr == `MGC_OFS_PIN0_CFG);
assign wr_pin12 = reg_wr & (reg_addr == `MGC_OFS_PIN12_CFG);
assign wr_pin3  = reg_wr & (reg_addr == `MGC_OFS_PIN3_CFG);
assign wr_pin56 = reg_wr & (reg_addr == `MGC_OFS_PIN56_CFG);

// Pin nibbles, the upper pin of the shared register in bits 7:4
assign nib[0] = pin0_cfg_q;
assign nib[1] = pin12_cfg_q[3:0];
assign nib[2] = pin12_cfg_q[7:4];
assign nib[3] = pin3_cfg_q;

////////////////////////////////////////////////////////////////////////////////
// Write decode

always @*
begin
  pin0_cfg_d  = pin0_cfg_q;
  pin12_cfg_d = pin12_cfg_q;
  pin3_cfg_d  = pin3_cfg_q;
  pin3_rsvd_d = pin3_rsvd_q;
  pin5_cfg_d  = pin5_cfg_q;
  pin6_cfg_d  = pin6_cfg_q;
  pin6_out_d  = pin_six_output_value;
  if (wr_pin0)
  begin
    pin0_cfg_d = reg_wdata[3:0];
  end
  if (wr_pin12)
  begin
    pin12_cfg_d = reg_wdata;
  end
  // Reserved nibble kept as plain storage
  if (wr_pin3)
  begin
    pin3_cfg_d  = reg_wdata[3:0];
    pin3_rsvd_d = reg_wdata[7:4];
  end
  // Pins 5 and 6 have no pad logic; only the pin 6 output value leaves, as pin_six_output_value
  if (wr_pin56)
  begin
    pin5_cfg_d = reg_wdata[3:0];
    pin6_cfg_d = reg_wdata[6:4];
    pin6_out_d = reg_wdata[7];
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register state

always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    pin0_cfg_q           <= `MGC_RST_NIBBLE;
    pin12_cfg_q          <= `MGC_RST_CFG;
    pin3_cfg_q           <= `MGC_RST_NIBBLE;
    pin3_rsvd_q          <= `MGC_RST_NIBBLE;
    pin5_cfg_q           <= `MGC_RST_NIBBLE;
    pin6_cfg_q           <= `MGC_RST_PIN6;
    pin_six_output_value <= `MGC_RST_BIT;
  end
  else
  begin
    pin0_cfg_q           <= pin0_cfg_d;
    pin12_cfg_q          <= pin12_cfg_d;
    pin3_cfg_q           <= pin3_cfg_d;
    pin3_rsvd_q          <= pin3_rsvd_d;
    pin5_cfg_q           <= pin5_cfg_d;
    pin6_cfg_q           <= pin6_cfg_d;
    pin_six_output_value <= pin6_out_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read path

always @*
begin
  rdata_d = `MGC_RST_CFG;
  if (reg_rd)
  begin
    case (reg_addr)
      `MGC_OFS_PIN0_CFG:  rdata_d = {`MGC_REVISION, pin0_cfg_q};
      `MGC_OFS_PIN12_CFG: rdata_d = pin12_cfg_q;
      `MGC_OFS_PIN3_CFG:  rdata_d = {pin3_rsvd_q, pin3_cfg_q};
      `MGC_OFS_PIN56_CFG: rdata_d = {pin_six_output_value, pin6_cfg_q, pin5_cfg_q};
      default:            rdata_d = `MGC_RST_CFG;
    endcase
  end
end

// Read data stands only in the cycle after the strobe, zero otherwise
always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    reg_rdata <= `MGC_RST_CFG;
  end
  else
  begin
    reg_rdata <= rdata_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
// Every asynchronous input crosses two flops; only the second stage is read

reg  [3:0] rem_s1_q;
reg  [3:0] rem_s2_q;
reg        sel_s1_q;
reg        sel_s2_q;
reg  [3:0] pin_s1_q;
reg  [3:0] pin_s2_q;
reg  [3:0] dpin_s1_q;
reg  [3:0] dpin_s2_q;
wire       port_sel;

// Link side: mirrored values and the port select
always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    rem_s1_q <= `MGC_RST_NIBBLE;
    rem_s2_q <= `MGC_RST_NIBBLE;
    sel_s1_q <= `MGC_RST_BIT;
    sel_s2_q <= `MGC_RST_BIT;
  end
  else
  begin
    rem_s1_q <= remote_pin_value;
    rem_s2_q <= rem_s1_q;
    sel_s1_q <= second_port_select;
    sel_s2_q <= sel_s1_q;
  end
end

// Pad side: inputs of both pin sets
always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    pin_s1_q  <= `MGC_RST_NIBBLE;
    pin_s2_q  <= `MGC_RST_NIBBLE;
    dpin_s1_q <= `MGC_RST_NIBBLE;
    dpin_s2_q <= `MGC_RST_NIBBLE;
  end
  else
  begin
    pin_s1_q  <= pin_in;
    pin_s2_q  <= pin_s1_q;
    dpin_s1_q <= second_set_pin_in;
    dpin_s2_q <= dpin_s1_q;
  end
end

assign port_sel = sel_s2_q;

////////////////////////////////////////////////////////////////////////////////
// Per-pin pad control

// Functional mode passes func_out_value straight through, so pads follow it at once

genvar i;
generate
  for (i = 0; i < 4; i = i + 1)
  begin : g_pin
    wire       en_bit;
    wire       dir_bit;
    wire       remote;
    wire       out_bit;
    wire [1:0] mode;
    reg        drv;
    reg        val;
    reg        pri_out;
    reg        pri_oe;
    reg        sec_out;
    reg        sec_oe;
    reg        in_sel;

    assign en_bit  = nib[i][`MGC_BIT_EN];
    assign dir_bit = nib[i][`MGC_BIT_DIR];
    assign remote  = nib[i][`MGC_BIT_REMOTE];
    assign out_bit = nib[i][`MGC_BIT_OUTVAL];
    assign mode    = {dir_bit, en_bit};

    always @*
    begin
      drv = 1'b0;
      val = 1'b0;
      if (remote)
      begin
        drv = 1'b1;
        val = rem_s2_q[i];
      end
      else
      begin
        case (mode)
          `MGC_MODE_FUNC:
          begin
            drv = 1'b1;
            val = func_out_value[i];
          end
          `MGC_MODE_GP_OUT:
          begin
            drv = 1'b1;
            val = out_bit;
          end
          `MGC_MODE_TRISTATE: drv = 1'b0;
          `MGC_MODE_GP_IN:    drv = 1'b0;
          default:            drv = 1'b0;
        endcase
      end
    end

    // second pin set steering
    // The unselected set is parked low and undriven
    always @*
    begin
      pri_out = 1'h0;
      pri_oe  = 1'h0;
      sec_out = 1'h0;
      sec_oe  = 1'h0;
      in_sel  = pin_s2_q[i];
      if (port_sel)
      begin
        sec_out = val;
        sec_oe  = drv;
        in_sel  = dpin_s2_q[i];
      end
      else
      begin
        pri_out = val;
        pri_oe  = drv;
      end
    end

    assign pin_out[i]            = pri_out;
    assign pin_oe[i]             = pri_oe;
    assign second_set_pin_out[i] = sec_out;
    assign second_set_pin_oe[i]  = sec_oe;
    assign pin_in_value[i]       = in_sel;
  end
endgenerate

endmodule

// file: mgc_gpio_regs.vh
// Purpose: Register offsets, field positions and reset values for the pin configuration block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes:   Definitions only
`ifndef MGC_GPIO_REGS_VH
`define MGC_GPIO_REGS_VH

`define MGC_ADDR_W            8
`define MGC_OFS_PIN0_CFG      8'h1d
`define MGC_OFS_PIN12_CFG     8'h1e
`define MGC_OFS_PIN3_CFG      8'h1f
`define MGC_OFS_PIN56_CFG     8'h20

`define MGC_BIT_EN            0
`define MGC_BIT_DIR           1
`define MGC_BIT_REMOTE        2
`define MGC_BIT_OUTVAL        3
`define MGC_UPPER_OFS         4

`define MGC_RST_CFG           8'h00
`define MGC_RST_NIBBLE        4'h0
`define MGC_RST_PIN6          3'h0
`define MGC_RST_BIT           1'h0
`define MGC_REVISION          4'h5

`define MGC_MODE_FUNC         2'b00
`define MGC_MODE_GP_OUT       2'b01
`define MGC_MODE_TRISTATE     2'b10
`define MGC_MODE_GP_IN        2'b11

`endif

// file: mgc_gpio_config_assertions.sv
// Purpose: Pad checker
// Assumes: Select low in reset
// Notes:   Watches pins 2 and 3
`timescale 1ns/1ns
`include "mgc_gpio_regs.vh"
module mgc_chk
(
  input wire       core_clk,
  input wire       rst_n,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire       second_port_select,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [3:0] func_out_value,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe,
  input wire [3:0] second_set_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Select crosses two flops, so wait three samples
  sequence lo; !second_port_select[*3]; endsequence
  sequence w3; lo ##0 reg_wr && reg_addr == 8'h1f; endsequence
  a_rev_rd: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1d |->
    reg_rdata[7:4] == `MGC_REVISION) else $error("revision");
  a_sel_two: assert property (second_port_select[*3] |=> !pin_oe) else $error("primary");
  a_sel_one: assert property (lo |=> !second_set_pin_oe) else $error("second");
  a_tri_in: assert property (w3 ##0 reg_wdata[2:1] == 2'h1 |=> !pin_oe[3])
    else $error("tristate");
  a_remote_on: assert property (w3 ##0 reg_wdata[2] |=> pin_oe[3]) else $error("remote");
  a_local_out: assert property (w3 ##0 reg_wdata[2:0] == 3'h1 |=>
    pin_out[3] == $past(reg_wdata[3])) else $error("local");
  a_func_out: assert property (w3 ##0 reg_wdata[2:0] == 3'h0 |=>
    pin_out[3] == func_out_value[3]) else $error("func");
  a_pin_two: assert property (lo ##0 reg_wr && reg_addr == 8'h1e && reg_wdata[6:5] == 2'h1
    |=> !pin_oe[2]) else $error("upper");
  a_reset_oe: assert property ($rose(rst_n) |-> &pin_oe) else $error("reset");
  c_sel: cover property (second_port_select[*3]);
  c_rd: cover property (reg_rd);
  c_w3: cover property (w3);
endmodule
////////////////////////////////
bind mgc_gpio_config mgc_chk u_chk (
  .core_clk           (core_clk),
  .rst_n              (rst_n),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .second_port_select (second_port_select),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_rdata          (reg_rdata),
  .func_out_value     (func_out_value),
  .pin_out            (pin_out),
  .pin_oe             (pin_oe),
  .second_set_pin_oe  (second_set_pin_oe)
);

// file: mgc_remote.sv
// Purpose: Remote serializer model
// Assumes: One link cycle of lag
// Notes:   Mirrors sent pin values
`timescale 1ns/1ns
module mgc_remote
(
  input wire       core_clk,
  input wire [3:0] send_value,
  output reg [3:0] remote_pin_value
);
  always @(posedge core_clk)
    remote_pin_value <= send_value;
endmodule

// file: tb_top.sv
// Purpose: Pin config tests
// Assumes: Remote lag under four cycles
// Notes:   Pin 3 carries the mode sweep
`timescale 1ns/1ns
`include "mgc_gpio_regs.vh"
module tb_top;
  logic       core_clk = 1'b0, rst_n, reg_wr, reg_rd, second_port_select, pin_six_output_value;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] remote_pin_value, func_out_value, pin_in, second_set_pin_in, send, pin_out;
  logic [3:0] pin_oe, second_set_pin_out, second_set_pin_oe, pin_in_value;
  int         fails, n_checks;
  mgc_gpio_config dut (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .second_port_select   (second_port_select),
    .remote_pin_value     (remote_pin_value),
    .func_out_value       (func_out_value),
    .pin_in               (pin_in),
    .second_set_pin_in    (second_set_pin_in),
    .pin_out              (pin_out),
    .pin_oe               (pin_oe),
    .second_set_pin_out   (second_set_pin_out),
    .second_set_pin_oe    (second_set_pin_oe),
    .pin_in_value         (pin_in_value),
    .pin_six_output_value (pin_six_output_value)
  );
  mgc_remote u_rem (.core_clk, .send_value(send), .remote_pin_value);
  initial forever #10 core_clk = ~core_clk;
  task chk(input logic [7:0] g, e);
    n_checks++;
    fails += (g !== e);
    if (g !== e) $display("[FAIL] %0t got %h want %h", $time, g, e);
  endtask
  // Read data stands one cycle only, so sample right after the edge
  task acc(input logic w, input logic [7:0] a, d);
    @(posedge core_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge core_clk);
    {reg_wr, reg_rd} <= 2'h0;
    #1;
    if (!w) chk(reg_rdata, d);
  endtask
  task conclude;
    $display("%0d checks %0d fails", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #99999 fails++;
    conclude;
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, second_port_select, reg_addr, reg_wdata} = 0;
    {func_out_value, pin_in, second_set_pin_in, send} = 16'h0698;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk({pin_oe, second_set_pin_oe}, 8'hf0);
    acc(0, 8'h1d, {`MGC_REVISION, 4'h0});
    for (int i = 1; i < 4; i++) acc(0, 8'h1d + 8'(i), 8'h00);
    chk(8'(pin_in_value), 8'h06);
    $display("reset test done");
    acc(1, 8'h1d, 8'hff);
    acc(0, 8'h1d, {`MGC_REVISION, 4'hf});
    acc(1, 8'h1e, 8'h3a);
    acc(0, 8'h1e, 8'h3a);
    chk(8'(pin_oe), 8'h09);
    acc(1, 8'h30, 8'hff);
    acc(0, 8'h30, 8'h00);
    acc(1, 8'h20, 8'h80);
    chk(8'(pin_six_output_value), 8'h01);
    $display("register test done");
    for (int m = 0; m < 4; m++)
    begin
      acc(1, 8'h1f, 8'h08 | 8'(m));
      chk(8'({pin_oe[3], pin_out[3] & pin_oe[3]}), m < 2 ? 8'h02 + 8'(m) : 8'h00);
    end
    acc(1, 8'h1f, 8'h06);
    chk(8'({pin_oe[3], pin_out[3]}), 8'h03);
    send <= 4'h0;
    repeat (4) @(posedge core_clk);
    #1 chk(8'({pin_oe[3], pin_out[3]}), 8'h02);
    second_port_select <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk({pin_oe, second_set_pin_oe}, 8'h09);
    chk(8'(pin_in_value), 8'h09);
    acc(1, 8'h1f, 8'h09);
    chk(8'({second_set_pin_oe[3], second_set_pin_out[3]}), 8'h03);
    $display("pad test done");
    conclude;
  end
endmodule
